// *** verilog/dac_channel_calibration_path.sv ***
// per-channel input, trim, calibrated and final code registers of a 40-channel converter
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - each group of eight channels has an 8-bit select register, reset zero
// - select bit n steers channel n of its group
// - one global command sets all select bits to zero or to one
// - input writes go to register A when bank bit is 0, else B
// - bank choice is a single global bit, no per-channel choice
// - each channel keeps inputs A and B, gain, offset, adjusted A and B, final
// - adjusted A/B computed from input A/B with gain and offset
// - one shared multiplier and adder, channels computed one after another
// - input, gain or offset writes recompute adjusted register of current bank
// - adjusted registers are not readable nor writable by software
// - load strobe low copies selected adjusted value into every final register
// - with strobe held low final registers follow new adjusted data
// - three 14-bit group offset codes: group 0, group 1, groups 2 to 4
// - code = input times (gain plus one) over 2^14 plus offset minus 2^13
// - inputs reset to 5461, gain to 2^14-1, offset to 2^13
// - computed code lies within 0 to 16383
// - group offset codes reset to 5461
// - outputs held at ground while hold input is low, registers stay writable
// - outputs held until the start-up sequence ends, then show defaults once the load strobe is low (final registers reset to zero)
// - bank bit is bit 2 of a 3-bit control register resetting to zero
// - hold low forces ground and ignores load, registers untouched
module dac_channel_calibration_path #(
   parameter int CHANNELS = 40
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // pins
   input wire logic i_load_strobe_n,
   input wire logic i_output_hold_n,
   // converter side
   output logic [CHANNELS*14-1:0] o_final_code,
   output logic [CHANNELS-1:0] o_signal_ground_level,
   output logic [41:0] o_group_offset_code,
   output logic [1:0] o_ctrl_misc
);
   localparam int CW = cal_path_pkg::CODE_W;
   localparam int PW = $clog2(CHANNELS);
   localparam int NG = (CHANNELS + 7) / 8;

   logic [CW-1:0] input_reg_a_q [CHANNELS];
   logic [CW-1:0] input_reg_b_q [CHANNELS];
   logic [CW-1:0] gain_q [CHANNELS];
   logic [CW-1:0] offs_q [CHANNELS];
   logic [CW-1:0] adjusted_a_q [CHANNELS];
   logic [CW-1:0] adjusted_b_q [CHANNELS];
   logic [CW-1:0] final_q [CHANNELS];
   logic [7:0] sel_q [NG];
   logic [CW-1:0] gofs_q [3];
   logic [2:0] ctrl_q;
   logic [PW-1:0] ptr_q;
   logic [15:0] rdata_q;
   logic [CHANNELS*CW-1:0] out_code_q;
   logic [CHANNELS-1:0] gnd_q;

   // pin synchronisers, three stages, change taken when stages 2 and 3 agree
   logic [2:0] ld_sync_q;
   logic [2:0] hold_sync_q;
   logic ld_n_q;
   logic hold_n_q;

   // pending recompute requests, one per channel and bank
   logic [CHANNELS-1:0] pend_a_q;
   logic [CHANNELS-1:0] pend_b_q;
   logic [CHANNELS-1:0] fresh_q;
   logic [PW-1:0] scan_q;
   logic [6:0] init_cnt_q;
   logic init_done_q;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CALC = 2'b10
   } calc_state_t;
   calc_state_t state_q;
   logic calc_bank_q;
   logic [PW-1:0] calc_ch_q;

   // decode
   wire bank = ctrl_q[cal_path_pkg::CTRL_BANK_BIT];
   wire wr_ctrl = i_wr && (i_addr == cal_path_pkg::ADDR_CONTROL);
   wire wr_sel_all = i_wr && (i_addr == cal_path_pkg::ADDR_SEL_ALL);
   wire wr_ptr = i_wr && (i_addr == cal_path_pkg::ADDR_CH_PTR);
   wire wr_in = i_wr && (i_addr == cal_path_pkg::ADDR_IN_DATA);
   wire wr_gain = i_wr && (i_addr == cal_path_pkg::ADDR_GAIN);
   wire wr_offs = i_wr && (i_addr == cal_path_pkg::ADDR_OFFS);
   wire wr_chan = wr_in || wr_gain || wr_offs;
   // a trim write recomputes only the bank in force, the other side keeps its old result
   wire mark_a = wr_chan && !bank;
   wire mark_b = wr_chan && bank;
   wire [7:0] sel_idx = i_addr - cal_path_pkg::ADDR_SEL_BASE;
   wire [7:0] ofs_idx = i_addr - cal_path_pkg::ADDR_OFS_BASE;
   wire wr_sel = i_wr && (i_addr >= cal_path_pkg::ADDR_SEL_BASE)
      && (sel_idx < 8'(NG));
   wire wr_gofs = i_wr && (i_addr >= cal_path_pkg::ADDR_OFS_BASE) && (ofs_idx < 8'h03);
   wire calc_busy = (state_q == ST_CALC) || (|pend_a_q) || (|pend_b_q);
   wire load_now = init_done_q && !ld_n_q && hold_n_q;
   wire release_out = hold_n_q && init_done_q;
   wire any_fresh = |fresh_q;
   wire init_long = init_cnt_q >= 7'(cal_path_pkg::INIT_CYCLES);

   // read decode
   wire rd_ctrl = (i_addr == cal_path_pkg::ADDR_CONTROL);
   wire rd_sel = (i_addr >= cal_path_pkg::ADDR_SEL_BASE) && (sel_idx < 8'(NG));
   wire rd_gofs = (i_addr >= cal_path_pkg::ADDR_OFS_BASE) && (ofs_idx < 8'h03);
   wire rd_stat = (i_addr == cal_path_pkg::ADDR_STATUS);
   wire rd_ptr = (i_addr == cal_path_pkg::ADDR_CH_PTR);
   wire rd_in = (i_addr == cal_path_pkg::ADDR_IN_DATA);
   wire rd_gain = (i_addr == cal_path_pkg::ADDR_GAIN);
   wire rd_offs = (i_addr == cal_path_pkg::ADDR_OFFS);

   // round-robin pick of next pending channel
   wire pick_a = pend_a_q[scan_q];
   wire pick_b = pend_b_q[scan_q];
   wire [PW-1:0] scan_next = (scan_q == PW'(CHANNELS - 1)) ? '0 : scan_q + 1'b1;

   // shared multiplier and adder, source by bank
   wire [CW-1:0] calc_in = calc_bank_q ? input_reg_b_q[calc_ch_q] : input_reg_a_q[calc_ch_q];
   wire [CW:0] gain_p1 = {1'b0, gain_q[calc_ch_q]} + 1'b1;
   wire [2*CW:0] product = calc_in * gain_p1;
   wire signed [CW+2:0] sum = $signed({2'b00, product[2*CW:CW]})
      + $signed({3'b000, offs_q[calc_ch_q]}) - (CW+3)'(cal_path_pkg::HALF_SCALE);
   // saturate to code range
   // clipping keeps a bad trim pair from wrapping to the far end of the span
   wire sum_neg = sum[CW+2];
   wire sum_high = sum > $signed((CW+3)'(cal_path_pkg::CODE_MAX));
   wire [CW-1:0] sat = sum_neg ? '0 : (sum_high ? cal_path_pkg::CODE_MAX : sum[CW-1:0]);

   // per-channel source choice, bit c%8 of group c/8
   logic [CW-1:0] picked [CHANNELS];
   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_pick
      assign picked[c] = sel_q[c/8][c%8] ? adjusted_b_q[c] : adjusted_a_q[c];
   end

   // read mux; adjusted and final codes have no read path
   logic [15:0] rd_mux;
   always_comb
   begin
      rd_mux = 16'h0000;
      if (rd_ctrl)
         rd_mux = {13'h0000, ctrl_q};
      else if (rd_sel)
         rd_mux = {8'h00, sel_q[sel_idx[2:0]]};
      else if (rd_gofs)
         rd_mux = {2'b00, gofs_q[ofs_idx[1:0]]};
      else if (rd_stat)
         rd_mux = {12'h000, any_fresh, init_done_q, hold_n_q, calc_busy};
      else if (rd_ptr)
         rd_mux = {{(16-PW){1'b0}}, ptr_q};
      else if (rd_in)
         rd_mux = {2'b00, bank ? input_reg_b_q[ptr_q] : input_reg_a_q[ptr_q]};
      else if (rd_gain)
         rd_mux = {2'b00, gain_q[ptr_q]};
      else if (rd_offs)
         rd_mux = {2'b00, offs_q[ptr_q]};
   end

   // control, select, group offsets, pointer, read data
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ctrl_q <= cal_path_pkg::CTRL_RESET;
         for (int g = 0; g < NG; g++)
         begin
            sel_q[g] <= cal_path_pkg::SEL_RESET;
         end
         for (int k = 0; k < 3; k++)
         begin
            gofs_q[k] <= cal_path_pkg::GROUP_OFS_RESET;
         end
         ptr_q <= '0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         // read data stand one cycle only, so a stale word is never taken for a live one
         rdata_q <= i_rd ? rd_mux : 16'h0000;
         if (wr_ctrl)
            ctrl_q <= i_wdata[cal_path_pkg::CTRL_W-1:0];
         // global select fill from data bit 0
         if (wr_sel_all)
         begin
            for (int g = 0; g < NG; g++)
            begin
               sel_q[g] <= {8{i_wdata[0]}};
            end
         end
         if (wr_sel)
         begin
            sel_q[sel_idx[2:0]] <= i_wdata[7:0];
         end
         // host keeps codes in range, stored as written
         if (wr_gofs)
         begin
            gofs_q[ofs_idx[1:0]] <= i_wdata[CW-1:0];
         end
         // pointers past the last channel are dropped, whole word compared
         if (wr_ptr && i_wdata < 16'(CHANNELS))
         begin
            ptr_q <= i_wdata[PW-1:0];
         end
      end
   end

   // pin synchronisers
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ld_sync_q <= 3'h7;
         hold_sync_q <= 3'h0;
         ld_n_q <= 1'b1;
         hold_n_q <= 1'b0;
      end
      else
      begin
         ld_sync_q <= {ld_sync_q[1:0], i_load_strobe_n};
         hold_sync_q <= {hold_sync_q[1:0], i_output_hold_n};
         // a glitch shorter than one clock never reaches the filtered level
         if (ld_sync_q[1] == ld_sync_q[2])
         begin
            ld_n_q <= ld_sync_q[2];
         end
         if (hold_sync_q[1] == hold_sync_q[2])
         begin
            hold_n_q <= hold_sync_q[2];
         end
      end
   end

   // channel registers, recompute engine and final registers
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            input_reg_a_q[c] <= cal_path_pkg::INPUT_RESET;
            input_reg_b_q[c] <= cal_path_pkg::INPUT_RESET;
            gain_q[c] <= cal_path_pkg::GAIN_RESET;
            offs_q[c] <= cal_path_pkg::OFFS_RESET;
            adjusted_a_q[c] <= '0;
            adjusted_b_q[c] <= '0;
            final_q[c] <= '0;
         end
         pend_a_q <= '1;
         pend_b_q <= '1;
         fresh_q <= '0;
         scan_q <= '0;
         state_q <= ST_IDLE;
         calc_bank_q <= 1'b0;
         calc_ch_q <= '0;
      end
      else
      begin
         if (wr_in && !bank)
            input_reg_a_q[ptr_q] <= i_wdata[CW-1:0];
         if (wr_in && bank)
            input_reg_b_q[ptr_q] <= i_wdata[CW-1:0];
         if (wr_gain)
            gain_q[ptr_q] <= i_wdata[CW-1:0];
         if (wr_offs)
            offs_q[ptr_q] <= i_wdata[CW-1:0];
         unique case (state_q)
            ST_IDLE:
            begin
               if (pick_a || pick_b)
               begin
                  calc_ch_q <= scan_q;
                  calc_bank_q <= !pick_a;
                  if (pick_a)
                     pend_a_q[scan_q] <= 1'b0;
                  else
                     pend_b_q[scan_q] <= 1'b0;
                  state_q <= ST_CALC;
               end
               else
               begin
                  scan_q <= scan_next;
               end
            end
            ST_CALC:
            begin
               // store result in adjusted register of its bank
               if (calc_bank_q)
                  adjusted_b_q[calc_ch_q] <= sat;
               else
                  adjusted_a_q[calc_ch_q] <= sat;
               state_q <= ST_IDLE;
            end
         endcase
         // writes mark recompute for bank in force; a new write wins over pickup
         if (mark_a)
            pend_a_q[ptr_q] <= 1'b1;
         if (mark_b)
            pend_b_q[ptr_q] <= 1'b1;
         // load on strobe low, ignored while held
         if (load_now)
         begin
            for (int c = 0; c < CHANNELS; c++)
            begin
               final_q[c] <= picked[c];
            end
            fresh_q <= '0;
         end
         // a result landing in the load cycle stays marked as not yet loaded
         if (state_q == ST_CALC)
            fresh_q[calc_ch_q] <= 1'b1;
      end
   end

   // start-up completion: defaults computed, then outputs released
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         init_cnt_q <= '0;
         init_done_q <= 1'b0;
      end
      else if (!init_done_q)
      begin
         // the floor keeps release from racing the first pickups of the walk
         if (!calc_busy && init_long)
            init_done_q <= 1'b1;
         if (!init_long)
            init_cnt_q <= init_cnt_q + 1'b1;
      end
   end

   // outputs; hold forces ground, final registers untouched
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         out_code_q <= '0;
         gnd_q <= '1;
      end
      else
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            out_code_q[c*CW +: CW] <= final_q[c];
            // held until start-up ends and while hold is low, one common level for every channel
            gnd_q[c] <= !release_out;
         end
      end
   end

   assign o_rdata = rdata_q;
   assign o_final_code = out_code_q;
   assign o_signal_ground_level = gnd_q;
   assign o_group_offset_code = {gofs_q[2], gofs_q[1], gofs_q[0]};
   assign o_ctrl_misc = ctrl_q[1:0];
endmodule

// *** verilog/cal_path_pkg.sv ***
// constants for the per-channel calibration data path
package cal_path_pkg;
   localparam int CODE_W = 14;
   localparam int GROUPS = 5;
   localparam int GROUP_CH = 8;
   localparam int CHANNELS = 40;
   // register addresses (8-bit word address space)
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SEL_BASE = 8'h01;
   localparam logic [7:0] ADDR_SEL_ALL = 8'h06;
   localparam logic [7:0] ADDR_OFS_BASE = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0b;
   localparam logic [7:0] ADDR_CH_PTR = 8'h0c;
   localparam logic [7:0] ADDR_IN_DATA = 8'h0d;
   localparam logic [7:0] ADDR_GAIN = 8'h0e;
   localparam logic [7:0] ADDR_OFFS = 8'h0f;
   localparam logic [7:0] ADDR_FINAL = 8'h10;
   // field positions and reset values
   localparam int CTRL_BANK_BIT = 2;
   localparam int CTRL_W = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [13:0] INPUT_RESET = 14'h1555;
   localparam logic [13:0] GAIN_RESET = 14'h3fff;
   localparam logic [13:0] OFFS_RESET = 14'h2000;
   localparam logic [13:0] GROUP_OFS_RESET = 14'h1555;
   localparam logic [13:0] CODE_MAX = 14'h3fff;
   localparam int HALF_SCALE = 8192;
   // cycles before start-up may complete (one per channel); the initialisation walk itself takes five per channel
   localparam int INIT_CYCLES = CHANNELS;
endpackage

// *** verification/cal_path_asserts.sv ***
// port-level assertions for the calibration data path
`timescale 1ns/1ps
module cal_path_asserts #(
   parameter int CHANNELS = 40
) (
   // clock, reset and register port
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   // pins and converter side
   input wire logic i_load_strobe_n,
   input wire logic i_output_hold_n,
   input wire logic [CHANNELS*14-1:0] o_final_code,
   input wire logic [CHANNELS-1:0] o_signal_ground_level,
   input wire logic [41:0] o_group_offset_code,
   input wire logic [1:0] o_ctrl_misc
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   wire ctl_wr = i_wr && i_addr == 8'h00;
   wire bad_rd = i_rd && (i_addr == 8'h07 || i_addr >= 8'h10);
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside answer");
   a_hidden_zero: assert property (bad_rd |=> o_rdata == 16'h0000)
      else $error("hidden address gave data");
   a_ctrl_readback: assert property (ctl_wr ##1 (i_rd && i_addr == 8'h00)
      |=> o_rdata[2:0] == $past(i_wdata[2:0], 2))
      else $error("control readback wrong");
   a_misc_follow: assert property (ctl_wr ##1 !ctl_wr
      |=> o_ctrl_misc == $past(i_wdata[1:0], 2))
      else $error("control bits not on pins");
   a_selall_read: assert property ((i_wr && i_addr == 8'h06) ##1 (i_rd && i_addr == 8'h03)
      |=> o_rdata[7:0] == {8{$past(i_wdata[0], 2)}})
      else $error("global select not applied");
   a_init_ground: assert property ($rose(i_resetn) |-> (&o_signal_ground_level) [*8])
      else $error("outputs released during init");
   a_ofs_default: assert property ($rose(i_resetn) |-> o_group_offset_code == {3{14'h1555}})
      else $error("group offset default wrong");
   a_hold_ground: assert property (!i_output_hold_n [*8] |-> &o_signal_ground_level)
      else $error("hold did not ground outputs");
   a_load_held: assert property (i_load_strobe_n [*7] |-> $stable(o_final_code))
      else $error("final changed without load");
   a_hold_freeze: assert property (!i_output_hold_n [*8] |-> $stable(o_final_code))
      else $error("load accepted under hold");
   c_load: cover property ($fell(i_load_strobe_n));
   c_input_wr: cover property (i_wr && i_addr == 8'h0d);
   c_hold_end: cover property ($rose(i_output_hold_n));
endmodule
bind dac_channel_calibration_path cal_path_asserts #(.CHANNELS(CHANNELS)) u_cal_path_asserts (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_load_strobe_n(i_load_strobe_n),
   .i_output_hold_n(i_output_hold_n), .o_final_code(o_final_code),
   .o_signal_ground_level(o_signal_ground_level),
   .o_group_offset_code(o_group_offset_code), .o_ctrl_misc(o_ctrl_misc));

// *** verification/host.sv ***
// register port master standing in for the host controller
`timescale 1ns/1ps
module host (
   // clock
   input wire logic i_mclk,
   // register port
   output logic [7:0] o_addr,
   output logic [15:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   input wire logic [15:0] i_rdata
);
   initial {o_addr, o_wdata, o_wr, o_rd} = 26'h0;
   // entered at a rising edge; strobe stays up so writes may follow with no gap
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      {o_addr, o_wdata, o_wr, o_rd} <= {a, d, 2'b10};
      @(posedge i_mclk);
   endtask
   // released lines are inverted so a stale value never passes for a live one
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      {o_addr, o_wdata, o_wr, o_rd} <= {a, ~o_wdata, 2'b01};
      @(posedge i_mclk);
      {o_addr, o_rd} <= {~a, 1'b0};
      // data stand between the two edges; take them mid-cycle, clear of both
      @(negedge i_mclk);
      d = i_rdata;
      @(posedge i_mclk);
   endtask
   task automatic idle(input int n);
      {o_addr, o_wdata, o_wr, o_rd} <= {~o_addr, ~o_wdata, 2'b00};
      repeat (n) @(posedge i_mclk);
   endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the calibration data path
`timescale 1ns/1ps
module tb;
   logic clk, rst_n, ld_n, hold_n, wr, rd;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [559:0] fin;
   logic [39:0] gnd, sel;
   logic [41:0] gofs_o, gofs;
   logic [1:0] misc;
   logic [2:0] ctl;
   logic [5:0] ptr;
   // bank-indexed model: [0] is the A side, [1] the B side
   logic [13:0] in_x[2][40], adj[2][40], gn[40], of[40], fexp[40];
   int error_cnt = 0, check_count = 0, seed = 32'hc99f;
   always #12.5 clk = ~clk;
   dac_channel_calibration_path #(.CHANNELS(40)) u_dac_channel_calibration_path (
      .i_mclk(clk), .i_resetn(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_load_strobe_n(ld_n), .i_output_hold_n(hold_n),
      .o_final_code(fin), .o_signal_ground_level(gnd), .o_group_offset_code(gofs_o),
      .o_ctrl_misc(misc));
   host u_host (.i_mclk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
      .i_rdata(rdata));
   function automatic logic [13:0] calc(logic [13:0] x, logic [13:0] m, logic [13:0] c);
      int v = ((int'(x) * (int'(m) + 1)) >>> 14) + int'(c) - 8192;
      return v < 0 ? 14'h0000 : v > 16383 ? 14'h3fff : 14'(v);
   endfunction
   task automatic chk_pin(input string n, input logic [41:0] e, input logic [41:0] g);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      u_host.rd(a, d);
      chk_pin("rdata", 42'(e), 42'(d));
   endtask
   // finals only follow the model where a load was accepted
   task automatic chk_fin(input bit take);
      for (int c = 0; c < 40; c++)
      begin
         if (take)
            fexp[c] = adj[sel[c]][c];
         chk_pin("final", 42'(fexp[c]), 42'(fin[c * 14 +: 14]));
      end
   endtask
   task automatic wrm(input logic [7:0] a, input logic [15:0] d);
      u_host.wr(a, d);
      case (a)
         8'h00: ctl = d[2:0];
         8'h01, 8'h02, 8'h03, 8'h04, 8'h05: sel[(a - 1) * 8 +: 8] = d[7:0];
         8'h06: sel = {40{d[0]}};
         8'h08, 8'h09, 8'h0a: gofs[(a - 8) * 14 +: 14] = d[13:0];
         8'h0c: ptr = d < 40 ? d[5:0] : ptr;
         8'h0d: in_x[ctl[2]][ptr] = d[13:0];
         8'h0e: gn[ptr] = d[13:0];
         8'h0f: of[ptr] = d[13:0];
         default: ;
      endcase
      // the other bank keeps a value computed with the old trim words
      if (a >= 8'h0d && a <= 8'h0f)
         adj[ctl[2]][ptr] = calc(in_x[ctl[2]][ptr], gn[ptr], of[ptr]);
   endtask
   task automatic do_reset;
      logic [15:0] s = 16'h0000;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      {ctl, sel, ptr, gofs} = {3'h0, 40'h0, 6'h0, {3{14'h1555}}};
      for (int c = 0; c < 40; c++)
         {in_x[0][c], in_x[1][c], gn[c], of[c], adj[0][c], adj[1][c], fexp[c]} =
            {14'h1555, 14'h1555, 14'h3fff, 14'h2000, 14'h1555, 14'h1555, 14'h0000};
      for (int i = 0; i < 150 && s[2] !== 1'b1; i++)
         u_host.rd(8'h0b, s);
      chk_pin("init_done", 42'h1, 42'(s[2]));
      u_host.idle(8);
      chk_pin("ground", 42'({40{!hold_n}}), 42'(gnd));
      chk_fin(hold_n);
      for (int a = 0; a < 6; a++)
         chk_rd(8'(a), 16'h0000);
      for (int a = 8; a < 11; a++)
         chk_rd(8'(a), 16'h1555);
      chk_rd(8'h0d, 16'h1555);
      chk_rd(8'h0e, 16'h3fff);
      chk_rd(8'h0f, 16'h2000);
      chk_rd(8'h07, 16'h0000);
      chk_rd(8'h10, 16'h0000);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      error_cnt++;
      test_done();
   end
   initial
   begin
      logic [13:0] g;
      {clk, rst_n, ld_n, hold_n} = 4'b0001;
      do_reset();
      for (int i = 0; i < 12; i++)
      begin
         wrm(8'h00, 16'($random(seed)) & 16'h0007);
         chk_rd(8'h00, {13'h0000, ctl});
         wrm(8'h0c, 16'({$random(seed)} % 40));
         if (i == 3)
            wrm(8'h0c, 16'h0028);
         g = i == 0 ? 14'h0000 : 14'($random(seed));
         wrm(8'h0e, {2'h0, g});
         wrm(8'h0f, i == 1 ? 16'h3fff : 16'($random(seed)) & 16'h3fff);
         wrm(8'h0d, 16'($random(seed)) & 16'h3fff);
         chk_rd(8'h0d, {2'h0, in_x[ctl[2]][ptr]});
         wrm(8'h01 + 8'(i % 5), 16'($random(seed)) & 16'h00ff);
         wrm(8'h08 + 8'(i % 3), 16'($random(seed)) & 16'h1fff); // kept under half scale
         if (i % 4 == 2)
         begin
            wrm(8'h06, 16'(i / 4 % 2));
            chk_rd(8'h03, {8'h00, sel[31:24]});
         end
         u_host.idle(200);
         chk_pin("ctrl_misc", 42'(ctl[1:0]), 42'(misc));
         chk_pin("grp_ofs", gofs, gofs_o);
         chk_fin(1'b1);
      end
      ld_n <= 1'b1;
      u_host.idle(8);
      wrm(8'h0d, 16'h0aaa);
      u_host.idle(200);
      chk_fin(1'b0);
      ld_n <= 1'b0;
      u_host.idle(8);
      chk_fin(1'b1);
      hold_n <= 1'b0;
      u_host.idle(10);
      chk_pin("ground", 42'({40{1'b1}}), 42'(gnd));
      wrm(8'h0d, 16'h1234);
      u_host.idle(200);
      chk_fin(1'b0);
      do_reset();
      wrm(8'h0d, 16'h2345);
      u_host.idle(200);
      chk_fin(1'b0);
      hold_n <= 1'b1;
      u_host.idle(10);
      chk_pin("ground", 42'h0, 42'(gnd));
      chk_fin(1'b1);
      test_done();
   end
endmodule
